// [sofh_fault_handler.v]
`include "sofh_defs.vh"
//Function
// R01 - Supply lockout disables FETs, auto recover
// R02 - Power-lost flag latched until cleared
// R03 - Regulator undervoltage disables FETs, auto recover
// R04 - Pump undervoltage: FETs off, fault, flags
// R05 - Pump recovery restarts; flag stays latched
// R06 - Pump protection always active
// R07 - Overvoltage: FETs off, fault, flags, restart
// R08 - Overvoltage enable gates all action
// R09 - Threshold select; pin variant fixed high
// R10 - Overcurrent needs deglitch time above threshold
// R11 - Two-bit overcurrent response field
// R12 - Pin variant uses latched shutdown
// R13 - Latched shutdown resumes after clear only; code also returns it to idle on power_down (supply lockout or regulator low)
// R14 - Retry mode restores after retry interval
// R15 - Report mode keeps driving, reports fault
// R16 - Disabled mode ignores overcurrent
// R17 - Fault pin low while faults remain
// R18 - Host clears latched flags after reading
module sofh_fault_handler #(
   parameter PIN_VARIANT = 0,
   parameter RETRY_CYCLES = (`SOFH_RETRY_US * 1000) / `SOFH_CLK_NS,
   parameter RST_CYCLES = (`SOFH_RST_PULSE_NS + `SOFH_CLK_NS - 1) / `SOFH_CLK_NS
)(
   input wire sys_clk,
   input wire srst,
   input wire supply_lockout,
   input wire regulator_low_event,
   input wire pump_undervoltage_event,
   input wire supply_over_low,
   input wire supply_over_high,
   input wire [`SOFH_NFET-1:0] fet_overcurrent,
   input wire sleep_reset_pin,
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg bridge_enable,
   output reg pump_enable,
   output reg logic_enable,
   output reg fault_out_pin,
   output reg irq
);
   localparam CW = `SOFH_CNT_W;
   localparam [CW-1:0] DEG0 = (`SOFH_DEG0_NS + `SOFH_CLK_NS - 1) / `SOFH_CLK_NS;
   localparam [CW-1:0] DEG1 = (`SOFH_DEG1_NS + `SOFH_CLK_NS - 1) / `SOFH_CLK_NS;
   localparam [CW-1:0] DEG2 = (`SOFH_DEG2_NS + `SOFH_CLK_NS - 1) / `SOFH_CLK_NS;
   localparam [CW-1:0] DEG3 = (`SOFH_DEG3_NS + `SOFH_CLK_NS - 1) / `SOFH_CLK_NS;
   localparam [CW-1:0] RETRY_MAX = RETRY_CYCLES;
   localparam [CW-1:0] RST_MAX = RST_CYCLES;
   localparam [1:0] OC_IDLE = 2'd0;
   localparam [1:0] OC_LATCHED = 2'd1;
   localparam [1:0] OC_RETRYING = 2'd2;
   localparam [1:0] OC_REPORTED = 2'd3;

   reg [5:0] cfg_reg;
   reg [`SOFH_NFET+4:0] flags_reg;
   reg [`SOFH_NFET+4:0] flags_prev_reg;
   reg [`SOFH_NFET+4:0] irq_stat_reg;
   reg [`SOFH_NFET+4:0] irq_mask_reg;
   reg power_lost_flag;
   reg [1:0] oc_state_reg;
   reg [CW-1:0] retry_cnt_reg;
   reg [CW-1:0] sleep_cnt_reg;
   reg sleep_prev_reg;
   reg clear_faults_cmd;
   reg [31:0] awaddr_reg;
   reg [31:0] wdata_reg;
   reg aw_full_reg;
   reg w_full_reg;
   wire rd_clear;
   reg [CW-1:0] deg_limit;
   wire [`SOFH_NFET-1:0] oc_seen;
   wire ov_enable;
   wire ov_high;
   wire ov_event;
   wire [1:0] oc_mode;
   wire any_oc;
   wire sleep_pulse;
   wire clear_any;
   wire power_down;
   wire [`SOFH_NFET+4:0] chip_status_word;

   function [CW-1:0] deg_pick;
      input [1:0] sel;
      begin
         case (sel)
            2'd0: deg_pick = DEG0;
            2'd1: deg_pick = DEG1;
            2'd2: deg_pick = DEG2;
            default: deg_pick = DEG3;
         endcase
      end
   endfunction

   always @*
   begin
      if (PIN_VARIANT != 0)
         deg_limit = DEG0; // see R10
      else
         deg_limit = deg_pick(cfg_reg[`SOFH_CFG_DEG_HI:`SOFH_CFG_DEG_LO]);
   end

   genvar g;
   generate
      for (g = 0; g < `SOFH_NFET; g = g + 1)
      begin : deg
         sofh_deglitch #(
            .CNT_W(CW)
         ) u_deg (
            .sys_clk(sys_clk),
            .srst(srst),
            .raw(fet_overcurrent[g]),
            .limit(deg_limit),
            .event_out(oc_seen[g])
         );
      end
   endgenerate

   assign any_oc = |oc_seen;
   // Pin variant: protection on, high threshold, latched response
   assign ov_enable = (PIN_VARIANT != 0) ? 1'b1 : cfg_reg[`SOFH_CFG_OV_EN]; // see R08
   assign ov_high = (PIN_VARIANT != 0) ? 1'b1 : cfg_reg[`SOFH_CFG_OV_SEL]; // see R09
   assign ov_event = ov_enable && (ov_high ? supply_over_high : supply_over_low); // see R07
   assign oc_mode = (PIN_VARIANT != 0) ? `SOFH_OC_LATCH : cfg_reg[`SOFH_CFG_OC_HI:`SOFH_CFG_OC_LO]; // see R11 R12
   // Host pulses the sleep pin low for the reset time to clear flags
   assign sleep_pulse = sleep_reset_pin && !sleep_prev_reg && (sleep_cnt_reg >= RST_MAX); // see R18
   assign clear_any = clear_faults_cmd || sleep_pulse;
   assign power_down = supply_lockout || regulator_low_event; // see R01 R03

   assign chip_status_word = flags_reg;
   // Clear at the accept edge so an event landing there survives the read
   assign rd_clear = s_axi_arvalid && s_axi_arready &&
      (s_axi_araddr[`SOFH_ADDR_W-1:0] == `SOFH_ADDR_IRQ_STAT);

   // Sleep pin low time measured here; long stays are still just a reset pulse
   always @(posedge sys_clk)
   begin
      if (srst)
      begin
         sleep_prev_reg <= 1'b1;
         sleep_cnt_reg <= {CW{1'b0}};
      end
      else
      begin
         sleep_prev_reg <= sleep_reset_pin;
         if (sleep_reset_pin)
            sleep_cnt_reg <= {CW{1'b0}};
         else if (sleep_cnt_reg < RST_MAX)
            sleep_cnt_reg <= sleep_cnt_reg + {{(CW-1){1'b0}}, 1'b1};
      end
   end

   // Overcurrent state machine
   always @(posedge sys_clk)
   begin
      if (srst || power_down)
      begin
         oc_state_reg <= OC_IDLE;
         retry_cnt_reg <= {CW{1'b0}};
      end
      else
      begin
         case (oc_state_reg)
            OC_IDLE:
            begin
               retry_cnt_reg <= {CW{1'b0}};
               if (any_oc)
               begin
                  if (oc_mode == `SOFH_OC_LATCH)
                     oc_state_reg <= OC_LATCHED; // see R13
                  else if (oc_mode == `SOFH_OC_RETRY)
                     oc_state_reg <= OC_RETRYING; // see R14
                  else if (oc_mode == `SOFH_OC_REPORT)
                     oc_state_reg <= OC_REPORTED; // see R15
                  // Disabled mode stays idle: see R16
               end
            end
            OC_LATCHED, OC_REPORTED:
            begin
               if (clear_any && !any_oc)
                  oc_state_reg <= OC_IDLE; // see R13 R15
            end
            default:
            begin
               if (retry_cnt_reg >= RETRY_MAX)
                  oc_state_reg <= OC_IDLE; // see R14
               else
                  retry_cnt_reg <= retry_cnt_reg + {{(CW-1){1'b0}}, 1'b1};
            end
         endcase
      end
   end

   // Sticky flags: a new event beats a clear in the same cycle
   always @(posedge sys_clk)
   begin
      if (srst)
      begin
         flags_reg <= {(`SOFH_NFET+5){1'b0}};
         power_lost_flag <= 1'b0;
      end
      else
      begin
         if (power_down)
            power_lost_flag <= 1'b0; // see R02
         else if (clear_any)
            power_lost_flag <= 1'b1;
         if (clear_any)
            flags_reg <= {(`SOFH_NFET+5){1'b0}};
         if (pump_undervoltage_event)
         begin
            flags_reg[`SOFH_ST_PUMP] <= 1'b1; // see R04 R05 R06
            flags_reg[`SOFH_ST_FAULT] <= 1'b1;
         end
         if (ov_event)
         begin
            flags_reg[`SOFH_ST_OV] <= 1'b1; // see R07
            flags_reg[`SOFH_ST_FAULT] <= 1'b1;
         end
         if (any_oc && oc_mode != `SOFH_OC_OFF)
         begin
            flags_reg[`SOFH_ST_OC] <= 1'b1; // see R13 R14 R15
            flags_reg[`SOFH_ST_FAULT] <= 1'b1;
            flags_reg[`SOFH_ST_FET_LO+`SOFH_NFET-1:`SOFH_ST_FET_LO] <=
               flags_reg[`SOFH_ST_FET_LO+`SOFH_NFET-1:`SOFH_ST_FET_LO] | oc_seen;
         end
         flags_reg[`SOFH_ST_PWR_OK] <= 1'b0;
      end
   end

   // Power stage and fault pin outputs
   always @(posedge sys_clk)
   begin
      if (srst)
      begin
         bridge_enable <= 1'b0;
         pump_enable <= 1'b0;
         logic_enable <= 1'b0;
         fault_out_pin <= 1'b1;
      end
      else
      begin
         logic_enable <= !power_down; // see R01 R03
         pump_enable <= !power_down;
         bridge_enable <= !(power_down || pump_undervoltage_event || ov_event ||
            oc_state_reg == OC_LATCHED || oc_state_reg == OC_RETRYING); // see R04 R05 R07 R13 R14 R15
         fault_out_pin <= !(pump_undervoltage_event || ov_event ||
            (oc_state_reg != OC_IDLE)); // see R17 R04 R07
      end
   end

   // Interrupt status set on flag rising, cleared by reading it
   always @(posedge sys_clk)
   begin
      if (srst)
      begin
         flags_prev_reg <= {(`SOFH_NFET+5){1'b0}};
         irq_stat_reg <= {(`SOFH_NFET+5){1'b0}};
         irq <= 1'b0;
      end
      else
      begin
         flags_prev_reg <= chip_status_word;
         irq_stat_reg <= (rd_clear ? {(`SOFH_NFET+5){1'b0}} : irq_stat_reg) |
            (chip_status_word & ~flags_prev_reg);
         irq <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // AXI4-Lite slave: one write and one read at a time
   always @(posedge sys_clk)
   begin
      if (srst)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         awaddr_reg <= 32'h00000000;
         wdata_reg <= 32'h00000000;
         cfg_reg <= `SOFH_CFG_RESET;
         irq_mask_reg <= {(`SOFH_NFET+5){1'b0}};
         clear_faults_cmd <= 1'b0;
      end
      else
      begin
         clear_faults_cmd <= 1'b0;
         if (s_axi_awvalid && s_axi_awready)
         begin
            awaddr_reg <= s_axi_awaddr;
            aw_full_reg <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wdata_reg <= s_axi_wdata;
            w_full_reg <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (aw_full_reg && w_full_reg && !s_axi_bvalid)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'b00;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            if (awaddr_reg[`SOFH_ADDR_W-1:0] == `SOFH_ADDR_CONFIG)
            begin
               cfg_reg <= wdata_reg[5:0];
            end
            else if (awaddr_reg[`SOFH_ADDR_W-1:0] == `SOFH_ADDR_CMD)
            begin
               clear_faults_cmd <= wdata_reg[`SOFH_CMD_CLEAR]; // see R18
            end
            else if (awaddr_reg[`SOFH_ADDR_W-1:0] == `SOFH_ADDR_IRQ_MASK)
            begin
               irq_mask_reg <= wdata_reg[`SOFH_NFET+4:0];
            end
            else if (awaddr_reg[`SOFH_ADDR_W-1:0] != `SOFH_ADDR_STATUS &&
               awaddr_reg[`SOFH_ADDR_W-1:0] != `SOFH_ADDR_IRQ_STAT)
            begin
               s_axi_bresp <= 2'b10;
            end
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always @(posedge sys_clk)
   begin
      if (srst)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
      end
      else
      begin
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            s_axi_rdata <= 32'h00000000;
            if (s_axi_araddr[`SOFH_ADDR_W-1:0] == `SOFH_ADDR_STATUS)
            begin
               s_axi_rdata[`SOFH_NFET+4:0] <= chip_status_word;
               s_axi_rdata[`SOFH_ST_PWR_OK] <= power_lost_flag;
            end
            else if (s_axi_araddr[`SOFH_ADDR_W-1:0] == `SOFH_ADDR_CONFIG)
               s_axi_rdata[5:0] <= cfg_reg;
            else if (s_axi_araddr[`SOFH_ADDR_W-1:0] == `SOFH_ADDR_CMD)
               s_axi_rdata <= 32'h00000000;
            else if (s_axi_araddr[`SOFH_ADDR_W-1:0] == `SOFH_ADDR_IRQ_STAT)
               s_axi_rdata[`SOFH_NFET+4:0] <= irq_stat_reg;
            else if (s_axi_araddr[`SOFH_ADDR_W-1:0] == `SOFH_ADDR_IRQ_MASK)
               s_axi_rdata[`SOFH_NFET+4:0] <= irq_mask_reg;
            else
               s_axi_rresp <= 2'b10;
         end
         if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule

// [sofh_defs.vh]
`ifndef SOFH_DEFS_VH
`define SOFH_DEFS_VH
// Register byte offsets
`define SOFH_ADDR_STATUS 5'h00
`define SOFH_ADDR_CONFIG 5'h04
`define SOFH_ADDR_CMD 5'h08
`define SOFH_ADDR_IRQ_STAT 5'h0c
`define SOFH_ADDR_IRQ_MASK 5'h10
`define SOFH_ADDR_W 5
// Config fields
`define SOFH_CFG_OV_EN 0
`define SOFH_CFG_OV_SEL 1
`define SOFH_CFG_OC_LO 2
`define SOFH_CFG_OC_HI 3
`define SOFH_CFG_DEG_LO 4
`define SOFH_CFG_DEG_HI 5
`define SOFH_CFG_RESET 6'h00
// Overcurrent response codes
`define SOFH_OC_LATCH 2'b00
`define SOFH_OC_RETRY 2'b01
`define SOFH_OC_REPORT 2'b10
`define SOFH_OC_OFF 2'b11
// Status bit positions
`define SOFH_ST_FAULT 0
`define SOFH_ST_PWR_OK 1
`define SOFH_ST_PUMP 2
`define SOFH_ST_OV 3
`define SOFH_ST_OC 4
`define SOFH_ST_FET_LO 5
`define SOFH_NFET 6
// Command bit
`define SOFH_CMD_CLEAR 0
// Timing: overcurrent deglitch in ns, indexed by selector
`define SOFH_DEG0_NS 600
`define SOFH_DEG1_NS 200
`define SOFH_DEG2_NS 1200
`define SOFH_DEG3_NS 1600
`define SOFH_CLK_NS 4
`define SOFH_RETRY_US 5000
`define SOFH_RST_PULSE_NS 1000
`define SOFH_CNT_W 24
`endif

// [sofh_deglitch.v]
`include "sofh_defs.vh"
module sofh_deglitch #(
   parameter CNT_W = 12
)(
   input wire sys_clk,
   input wire srst,
   input wire raw,
   input wire [CNT_W-1:0] limit,
   output reg event_out
);
   reg [CNT_W-1:0] cnt_reg;
   // Event only when the level stays high past the limit
   always @(posedge sys_clk)
   begin
      if (srst || !raw)
      begin
         cnt_reg <= {CNT_W{1'b0}};
         event_out <= 1'b0;
      end
      else if (cnt_reg < limit)
      begin
         cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
         event_out <= 1'b0;
      end
      else
      begin
         event_out <= 1'b1; // see R10
      end
   end
endmodule

// [sofh_fault_checker_sva.sv]
`include "sofh_defs.vh"
module sofh_fault_checker #(
   parameter PIN_VARIANT = 0
)(
   input wire sys_clk,
   input wire srst,
   input wire supply_lockout,
   input wire regulator_low_event,
   input wire pump_undervoltage_event,
   input wire supply_over_low,
   input wire supply_over_high,
   input wire [`SOFH_NFET-1:0] fet_overcurrent,
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire bridge_enable,
   input wire pump_enable,
   input wire logic_enable,
   input wire fault_out_pin
);
   // Shadow of the config word, committed at the write response
   logic [5:0] cfg_reg;
   logic [4:0] wa_reg;
   logic [5:0] wd_reg;
   logic [9:0] run_reg;
   wire ov_en = PIN_VARIANT ? 1'b1 : cfg_reg[`SOFH_CFG_OV_EN];
   wire ov_hi = PIN_VARIANT ? 1'b1 : cfg_reg[`SOFH_CFG_OV_SEL];
   wire [1:0] mode = PIN_VARIANT ? `SOFH_OC_LATCH : cfg_reg[`SOFH_CFG_OC_HI:`SOFH_CFG_OC_LO];
   wire deg0 = PIN_VARIANT ? 1'b1 : cfg_reg[`SOFH_CFG_DEG_HI:`SOFH_CFG_DEG_LO] == 2'b00;
   wire calm = !supply_lockout && !regulator_low_event && !pump_undervoltage_event;
   wire quiet = calm && !supply_over_low && !supply_over_high;
   always @(posedge sys_clk)
   begin
      if (srst)
      begin
         cfg_reg <= `SOFH_CFG_RESET;
         run_reg <= 10'h000;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
            wa_reg <= s_axi_awaddr[4:0];
         if (s_axi_wvalid && s_axi_wready)
            wd_reg <= s_axi_wdata[5:0];
         if (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'b00 && wa_reg == `SOFH_ADDR_CONFIG)
            cfg_reg <= wd_reg;
         run_reg <= (fet_overcurrent == 6'h00) ? 10'h000 : (run_reg == 10'h3ff) ? run_reg : run_reg + 10'h001;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   sequence s_calm;
      (fet_overcurrent == 6'h00 && calm)[*3];
   endsequence
   a_lockout_all_off: assert property (supply_lockout |=> !bridge_enable && !pump_enable && !logic_enable)
      else $error("lockout left outputs enabled");
   a_regulator_all_off: assert property (regulator_low_event |=> !bridge_enable && !pump_enable && !logic_enable)
      else $error("regulator low left outputs enabled");
   a_pump_low_fault: assert property ((pump_undervoltage_event && !supply_lockout && !regulator_low_event)
      |=> !bridge_enable && !fault_out_pin && logic_enable) else $error("pump low not handled");
   a_ov_trip_level: assert property ((ov_en && (ov_hi ? supply_over_high : supply_over_low))
      |=> !bridge_enable && !fault_out_pin) else $error("overvoltage not acted on");
   a_ov_off_quiet: assert property ((s_calm ##0 (!ov_en && supply_over_high && fault_out_pin)) |=> fault_out_pin)
      else $error("disabled overvoltage reported");
   a_deglitch_hold: assert property ((fet_overcurrent != 6'h00 && run_reg < 10'd140 && deg0 && quiet && fault_out_pin)
      |=> fault_out_pin) else $error("overcurrent tripped too early");
   a_deglitch_trip: assert property ((run_reg == 10'd160 && deg0 && mode != `SOFH_OC_OFF && quiet)
      |-> !fault_out_pin) else $error("overcurrent not reported");
   a_report_keeps_drive: assert property ((mode == `SOFH_OC_REPORT && quiet) |=> bridge_enable)
      else $error("report mode stopped the bridge");
   a_oc_off_silent: assert property ((mode == `SOFH_OC_OFF && quiet && fault_out_pin) |=> fault_out_pin)
      else $error("disabled overcurrent reported");
endmodule
bind sofh_fault_handler sofh_fault_checker #(.PIN_VARIANT(PIN_VARIANT)) chk (.sys_clk(sys_clk), .srst(srst),
   .supply_lockout(supply_lockout), .regulator_low_event(regulator_low_event),
   .pump_undervoltage_event(pump_undervoltage_event), .supply_over_low(supply_over_low),
   .supply_over_high(supply_over_high), .fet_overcurrent(fet_overcurrent), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .bridge_enable(bridge_enable),
   .pump_enable(pump_enable), .logic_enable(logic_enable), .fault_out_pin(fault_out_pin));

// [sofh_comparator_model.sv]
module sofh_comparator_model #(
   parameter SUPPLY_LOCKOUT_V = 4,
   parameter OV_LOW_V = 22,
   parameter OV_HIGH_V = 34
)(
   input wire sys_clk,
   input wire [5:0] vm_volts,
   output logic supply_lockout = 1'b0,
   output logic supply_over_low = 1'b0,
   output logic supply_over_high = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   // Comparators settle one clock after the supply moves
   always @(posedge sys_clk)
   begin
      supply_lockout <= vm_volts < SUPPLY_LOCKOUT_V;
      supply_over_low <= vm_volts > OV_LOW_V;
      supply_over_high <= vm_volts > OV_HIGH_V;
   end
endmodule

// [test_supply_overcurrent_fault_handler.sv]
`include "sofh_defs.vh"
module test_supply_overcurrent_fault_handler;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0, srst = 1'b1, reg_low = 1'b0, pump_low = 1'b0, sleep_n = 1'b1;
   logic [5:0] fet_oc = 6'h00, volts = 6'h14;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rd;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [1:0] rs;
   wire lockout, over_lo, over_hi, awready, wready, bvalid, arready, rvalid, bridge_en, pump_en, logic_en;
   wire fault_n, irq;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   int failures = 0, total_checks = 0, cycles = 0;
   always #2 sys_clk = ~sys_clk;
   sofh_comparator_model cmp (.sys_clk(sys_clk), .vm_volts(volts), .supply_lockout(lockout),
      .supply_over_low(over_lo), .supply_over_high(over_hi));
   // Short retry and clear-pulse counts keep the run brief
   sofh_fault_handler #(.PIN_VARIANT(0), .RETRY_CYCLES(20), .RST_CYCLES(4)) uut (.sys_clk(sys_clk), .srst(srst),
      .supply_lockout(lockout), .regulator_low_event(reg_low), .pump_undervoltage_event(pump_low),
      .supply_over_low(over_lo), .supply_over_high(over_hi), .fet_overcurrent(fet_oc), .sleep_reset_pin(sleep_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .bridge_enable(bridge_en), .pump_enable(pump_en), .logic_enable(logic_en),
      .fault_out_pin(fault_n), .irq(irq));
   task automatic close_out();
      if (failures == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // Checks land 1 ns after the edge so registered outputs have settled
   task automatic pins(input logic eb, input logic ef);
      #1;
      check({30'h0, bridge_en, fault_n}, {30'h0, eb, ef});
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      awaddr <= {27'h0, a};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever
      begin
         @(posedge sys_clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid)
            break;
      end
      rs = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd_reg(input logic [4:0] a);
      @(posedge sys_clk);
      araddr <= {27'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever
      begin
         @(posedge sys_clk);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid)
            break;
      end
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   task automatic st(input logic [31:0] e);
      rd_reg(`SOFH_ADDR_STATUS);
      check(rd, e);
   endtask
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         close_out();
      end
   end
   initial
   begin
      logic [1:0] c;
      logic t;
      step(3);
      srst <= 1'b0;
      step(2);
      pins(1'b1, 1'b1);
      st(32'h0);
      rd_reg(5'h14);
      check(rs, 2'b10);
      wr(5'h14, 32'h1);
      check(rs, 2'b10);
      wr(`SOFH_ADDR_CMD, 32'h1);
      st(32'h2);
      for (int i = 0; i < 2; i++)
      begin
         if (i == 0)
            volts <= 6'h03;
         else
            reg_low <= 1'b1;
         step(3);
         pins(1'b0, 1'b1);
         check({pump_en, logic_en}, 2'b00);
         volts <= 6'h14;
         reg_low <= 1'b0;
         step(3);
         pins(1'b1, 1'b1);
         check({pump_en, logic_en}, 2'b11);
         st(32'h0);
         wr(`SOFH_ADDR_CMD, 32'h1);
         st(32'h2);
      end
      pump_low <= 1'b1;
      step(2);
      pins(1'b0, 1'b0);
      check(logic_en, 1'b1);
      pump_low <= 1'b0;
      step(2);
      pins(1'b1, 1'b1);
      st(32'h7);
      wr(`SOFH_ADDR_CMD, 32'h1);
      st(32'h2);
      for (int i = 0; i < 6; i++)
      begin
         c = (i < 2) ? 2'b00 : (i < 4) ? 2'b01 : 2'b11;
         t = c[0] && (!c[1] || i[0]);
         wr(`SOFH_ADDR_CONFIG, {30'h0, c});
         volts <= i[0] ? 6'h24 : 6'h1c;
         step(3);
         pins(!t, !t);
         volts <= 6'h14;
         step(3);
         pins(1'b1, 1'b1);
         st(t ? 32'hb : 32'h2);
         wr(`SOFH_ADDR_CMD, 32'h1);
      end
      for (int m = 0; m < 4; m++)
      begin
         wr(`SOFH_ADDR_CONFIG, {28'h0, m[1:0], 2'b00});
         fet_oc <= 6'h01 << m;
         step(100);
         pins(1'b1, 1'b1);
         fet_oc <= 6'h00;
         step(2);
         fet_oc <= 6'h01 << m;
         step(165);
         pins(m >= 2, m == 3);
         fet_oc <= 6'h00;
         step(30);
         pins(m != 0, m == 1 || m == 3);
         st(m < 3 ? 32'h13 | (32'h20 << m) : 32'h2);
         wr(`SOFH_ADDR_CMD, 32'h1);
         step(2);
         pins(1'b1, 1'b1);
      end
      // Second deglitch setting: 50 cycles, report mode
      wr(`SOFH_ADDR_CONFIG, 32'h18);
      fet_oc <= 6'h01;
      step(45);
      pins(1'b1, 1'b1);
      step(10);
      pins(1'b1, 1'b0);
      fet_oc <= 6'h00;
      st(32'h33);
      wr(`SOFH_ADDR_CMD, 32'h1);
      step(2);
      pins(1'b1, 1'b1);
      rd_reg(`SOFH_ADDR_IRQ_STAT);
      wr(`SOFH_ADDR_IRQ_MASK, 32'h0);
      pump_low <= 1'b1;
      step(1);
      pump_low <= 1'b0;
      step(4);
      #1 check(irq, 1'b0);
      wr(`SOFH_ADDR_IRQ_MASK, 32'h4);
      step(3);
      #1 check(irq, 1'b1);
      rd_reg(`SOFH_ADDR_IRQ_STAT);
      check(rd, 32'h5);
      step(3);
      #1 check(irq, 1'b0);
      @(posedge sys_clk);
      sleep_n <= 1'b0;
      step(6);
      sleep_n <= 1'b1;
      step(3);
      st(32'h2);
      close_out();
   end
endmodule
